// [src/pfss_defs.vh]
`ifndef PFSS_DEFS_VH
`define PFSS_DEFS_VH
`define PFSS_RST_ACTIVE       1'B1
`define PFSS_TAMPER_ACTIVE    1'B1
`define PFSS_WARN_VECTOR      8'H2B
`define PFSS_CE_WIDTH         4
`define PFSS_CE_INACTIVE      4'HF
`define PFSS_CLK_HZ           20000000
`define PFSS_CUT_TIME_NS      1000
`define PFSS_CUT_CYCLES       ((`PFSS_CUT_TIME_NS * (`PFSS_CLK_HZ / 1000000)) / 1000)
`define PFSS_CNT_WIDTH        8
`define PFSS_WARN_EN_RESET    1'B0
`endif

// [src/pfss_sync.v]
`timescale 1ns/1ps
`default_nettype none
module pfss_sync
#(
  parameter [0:0] RESET_VAL = 1'B0
)
(
  input  wire clk_sys,
  input  wire rst_b,
  input  wire din,
  output reg  dout
);
  reg meta;
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta <= RESET_VAL;
      dout <= RESET_VAL;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire

// [src/pfss_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "pfss_defs.vh"
module pfss_top
(
  input  wire                       clk_sys,
  input  wire                       rst_b,
  input  wire                       reset_pin,
  input  wire                       loader_request_n,
  input  wire                       tamper_erase_in,
  input  wire                       below_warning,
  input  wire                       below_min_operating,
  input  wire                       below_backup_switch,
  input  wire                       warn_enable_wr,
  input  wire                       warn_enable_data,
  input  wire [`PFSS_CE_WIDTH-1:0]  core_chip_enable_n,
  input  wire                       core_rw_n,
  output reg                        core_reset,
  output reg                        loader_start,
  output reg                        boot_to_loader,
  output reg                        key_erase,
  output reg                        vector_erase,
  output reg                        switched_memory_supply,
  output reg                        warn_irq,
  output reg  [7:0]                 warn_vector,
  output reg                        warn_status,
  output reg                        warn_enable,
  output reg                        backup_mode,
  output reg                        circuits_disable,
  output reg  [`PFSS_CE_WIDTH-1:0]  mem_chip_enable_n,
  output reg                        mem_rw_n
);
  localparam [2:0] ST_IDLE = 3'B001;
  localparam [2:0] ST_CUT  = 3'B010;
  localparam [2:0] ST_HOLD = 3'B100;
  localparam [31:0] CUT_TOTAL = `PFSS_CUT_CYCLES;
  // the count is an integer expression; keep only the counter's bits
  localparam [`PFSS_CNT_WIDTH-1:0] CUT_CYCLES =
    CUT_TOTAL[`PFSS_CNT_WIDTH-1:0];

  reg                       rst_meta;
  reg                       rst_sync_b;
  wire                      s_reset;
  wire                      s_loader_req;
  wire                      s_tamper;
  wire                      s_warn;
  wire                      s_min;
  wire                      s_backup;
  reg                       loader_prev;
  reg                       boot_sampled;
  reg  [1:0]                sync_fill;
  reg  [2:0]                state;
  reg  [2:0]                next_state;
  reg  [`PFSS_CNT_WIDTH-1:0] cnt;
  reg  [`PFSS_CNT_WIDTH-1:0] next_cnt;
  wire                      low_supply;
  wire                      settled;
  wire                      strobe_block;

  // one decode shared by the erase, supply and reset outputs
  function is_cut;
    input [2:0] st;
    begin
      is_cut = (st == ST_CUT);
    end
  endfunction

  // reset leaves through two flops so every flop sees it at one edge
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta   <= 1'B0;
      rst_sync_b <= 1'B0;
    end
    else
    begin
      rst_meta   <= 1'B1;
      rst_sync_b <= rst_meta;
    end
  end

  // pins and comparators are asynchronous; all pass two flops first
  pfss_sync
  #(
    .RESET_VAL (1'B0)
  )
  u_sync_rst
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_sync_b),
    .din       (reset_pin),
    .dout      (s_reset)
  );

  // the loader pin is inverted ahead of the flops, so idle reads low
  pfss_sync
  #(
    .RESET_VAL (1'B0)
  )
  u_sync_loader
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_sync_b),
    .din       (~loader_request_n),
    .dout      (s_loader_req)
  );

  pfss_sync
  #(
    .RESET_VAL (1'B0)
  )
  u_sync_tamper
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_sync_b),
    .din       (tamper_erase_in),
    .dout      (s_tamper)
  );

  pfss_sync
  #(
    .RESET_VAL (1'B0)
  )
  u_sync_warn
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_sync_b),
    .din       (below_warning),
    .dout      (s_warn)
  );

  pfss_sync
  #(
    .RESET_VAL (1'B0)
  )
  u_sync_min
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_sync_b),
    .din       (below_min_operating),
    .dout      (s_min)
  );

  pfss_sync
  #(
    .RESET_VAL (1'B0)
  )
  u_sync_backup
  (
    .clk_sys   (clk_sys),
    .rst_b     (rst_sync_b),
    .din       (below_backup_switch),
    .dout      (s_backup)
  );

  // backup implies min implies warning, even if comparators disagree
  assign low_supply = s_min | s_backup;

  // synchroniser outputs mean nothing until both flops have refilled
  assign settled      = sync_fill[1];
  assign strobe_block = low_supply | ~settled;

  // s_loader_req is the inverted pin, so high means request pin low
  always @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      sync_fill    <= 2'B00;
      loader_prev  <= 1'B0;
      boot_sampled <= 1'B0;
      loader_start <= 1'B0;
    end
    else
    begin
      sync_fill    <= {sync_fill[0], 1'B1};
      loader_prev  <= s_loader_req;
      // the strap cycle is no edge: a pin held low gives no start
      loader_start <= s_loader_req & ~loader_prev & boot_sampled;
      if (settled)
        boot_sampled <= 1'B1;
    end
  end

  // level at first settled cycle after release acts as the boot strap
  always @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
      boot_to_loader <= 1'B0;
    else if (!boot_sampled)
      boot_to_loader <= s_loader_req & settled;
    else if (s_loader_req & ~loader_prev)
      boot_to_loader <= 1'B1;
    else if (core_reset & ~s_loader_req)
      boot_to_loader <= 1'B0;
  end

  always @*
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_IDLE:
      begin
        if (s_tamper == `PFSS_TAMPER_ACTIVE)
        begin
          next_state = ST_CUT;
          next_cnt   = CUT_CYCLES;
        end
      end
      ST_CUT:
      begin
        if (cnt <= 8'H01)
          next_state = ST_HOLD;
        else
          next_cnt = cnt - 8'H01;
      end
      ST_HOLD:
      begin
        // one unlock per high level; a new one needs the pin to drop
        if (s_tamper != `PFSS_TAMPER_ACTIVE)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      state                  <= ST_IDLE;
      cnt                    <= 8'H00;
      key_erase              <= 1'B0;
      vector_erase           <= 1'B0;
      switched_memory_supply <= 1'B1;
    end
    else
    begin
      state                  <= next_state;
      cnt                    <= next_cnt;
      key_erase              <= is_cut(next_state);
      vector_erase           <= is_cut(next_state);
      switched_memory_supply <= ~is_cut(next_state) & ~s_backup;
    end
  end

  always @(posedge clk_sys or negedge rst_sync_b)
  begin
    if (!rst_sync_b)
    begin
      core_reset        <= 1'B1;
      warn_enable       <= `PFSS_WARN_EN_RESET;
      warn_status       <= 1'B0;
      warn_irq          <= 1'B0;
      warn_vector       <= `PFSS_WARN_VECTOR;
      backup_mode       <= 1'B0;
      circuits_disable  <= 1'B0;
      mem_chip_enable_n <= `PFSS_CE_INACTIVE;
      mem_rw_n          <= 1'B1;
    end
    else
    begin
      // reset pin, low supply and an unlock all hold the core in reset
      // until the flops refill the pin and supply levels are not known
      core_reset <= (s_reset == `PFSS_RST_ACTIVE) | low_supply
                    | is_cut(next_state) | ~settled;
      if (warn_enable_wr)
        warn_enable <= warn_enable_data;
      warn_status <= s_warn | low_supply;
      // interrupt only; never feeds core_reset or a stall
      warn_irq    <= (s_warn | low_supply) & warn_enable;
      warn_vector <= `PFSS_WARN_VECTOR;
      backup_mode      <= s_backup;
      circuits_disable <= s_backup;
      // strobes stay parked high until the supply flags can be trusted
      if (strobe_block)
      begin
        mem_chip_enable_n <= `PFSS_CE_INACTIVE;
        mem_rw_n          <= 1'B1;
      end
      else
      begin
        mem_chip_enable_n <= core_chip_enable_n;
        mem_rw_n          <= core_rw_n;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/pfss_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module pfss_checker
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       reset_pin,
  input wire logic       loader_request_n,
  input wire logic       tamper_erase_in,
  input wire logic       below_min_operating,
  input wire logic       below_backup_switch,
  input wire logic       warn_enable_wr,
  input wire logic       warn_enable_data,
  input wire logic [3:0] core_chip_enable_n,
  input wire logic       core_rw_n,
  input wire logic       core_reset,
  input wire logic       loader_start,
  input wire logic       key_erase,
  input wire logic       switched_memory_supply,
  input wire logic       warn_irq,
  input wire logic       warn_status,
  input wire logic       warn_enable,
  input wire logic [3:0] mem_chip_enable_n,
  input wire logic       mem_rw_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // pins pass two sync flops, so levels are held a few samples first
  wire logic low_sup = below_min_operating | below_backup_switch;
  a_pin_reset: assert property (reset_pin[*4] |-> core_reset)
    else $error("pin reset not held");
  a_strobe_off: assert property (low_sup[*6] |->
    mem_chip_enable_n == 4'HF && mem_rw_n) else $error("strobes active");
  a_strobe_pass: assert property ((!low_sup)[*6] |->
    mem_chip_enable_n == $past(core_chip_enable_n)
    && mem_rw_n == $past(core_rw_n)) else $error("strobes not passed");
  a_irq_gate: assert property (warn_irq ==
    (warn_status && $past(warn_enable))) else $error("irq gating");
  a_enable_write: assert property (warn_enable_wr |=>
    warn_enable == $past(warn_enable_data)) else $error("enable write");
  a_tamper_unlock: assert property ($rose(tamper_erase_in) |->
    ##[2:4] key_erase && !switched_memory_supply) else $error("no unlock");
  a_cut_length: assert property ($rose(key_erase) |->
    ##19 key_erase ##1 !key_erase) else $error("cut length");
  a_loader_edge: assert property ($fell(loader_request_n) |->
    ##[2:4] loader_start) else $error("no loader start");
  cover property ($rose(key_erase));
  cover property (warn_irq);
  cover property (loader_start);
endmodule
`default_nettype wire

// [tb/pfss_board.sv]
`timescale 1ns/1ps
`default_nettype none
module pfss_board
(
  input  wire logic clk_sys,
  output var  logic reset_pin,
  output var  logic loader_request_n,
  output var  logic tamper_erase_in,
  output var  logic below_warning,
  output var  logic below_min_operating,
  output var  logic below_backup_switch
);
  // deeper levels imply the shallower flags, as ordered comparators do
  task automatic supply(input logic [1:0] lvl);
    below_warning = lvl >= 2'H1;
    below_min_operating = lvl >= 2'H2;
    below_backup_switch = lvl == 2'H3;
  endtask
  initial
  begin
    reset_pin = 1'B0;
    loader_request_n = 1'B1;
    tamper_erase_in = 1'B0;
    supply(2'H0);
  end
endmodule
`default_nettype wire

// [tb/pfss_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module pfss_top_bench;
  logic            clk_sys;
  logic            rst_b;
  logic            warn_enable_wr;
  logic            warn_enable_data;
  logic [3:0]      core_chip_enable_n;
  logic            core_rw_n;
  int              fails = 0;
  int              num_checks = 0;
  wire logic       reset_pin, loader_request_n, tamper_erase_in;
  wire logic       below_warning, below_min_operating, below_backup_switch;
  wire logic       core_reset, loader_start, boot_to_loader, key_erase;
  wire logic       vector_erase, switched_memory_supply, warn_irq;
  wire logic       warn_status, warn_enable, backup_mode, circuits_disable;
  wire logic       mem_rw_n;
  wire logic [7:0] warn_vector;
  wire logic [3:0] mem_chip_enable_n;
  pfss_board u_board (.clk_sys, .reset_pin, .loader_request_n,
    .tamper_erase_in, .below_warning, .below_min_operating,
    .below_backup_switch);
  pfss_top u_pfss_top (.clk_sys, .rst_b, .reset_pin, .loader_request_n,
    .tamper_erase_in, .below_warning, .below_min_operating,
    .below_backup_switch, .warn_enable_wr, .warn_enable_data,
    .core_chip_enable_n, .core_rw_n, .core_reset, .loader_start,
    .boot_to_loader, .key_erase, .vector_erase, .switched_memory_supply,
    .warn_irq, .warn_vector, .warn_status, .warn_enable, .backup_mode,
    .circuits_disable, .mem_chip_enable_n, .mem_rw_n);
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset;
    rst_b = 1'B0;
    step(3);
    rst_b = 1'B1;
    step(8);
  endtask
  task automatic set_warn(input logic v);
    warn_enable_wr = 1'B1;
    warn_enable_data = v;
    step(1);
    warn_enable_wr = 1'B0;
  endtask
  task automatic t_pins;
    int n = 0;
    u_board.reset_pin = 1'B1;
    step(5);
    check(core_reset, 1'B1);
    u_board.reset_pin = 1'B0;
    step(5);
    check(core_reset, 1'B0);
    // one clean edge, held low, as a debounced switch gives
    u_board.loader_request_n = 1'B0;
    repeat (8)
    begin
      step(1);
      n += loader_start;
    end
    check(n[7:0], 8'H01);
    do_reset;
    check({boot_to_loader, loader_start}, 2'H2);
    u_board.loader_request_n = 1'B1;
  endtask
  task automatic t_tamper;
    int k = 0;
    int s = 0;
    // held far past the cut: a second unlock would show in the counts
    u_board.tamper_erase_in = 1'B1;
    repeat (40)
    begin
      step(1);
      k += key_erase & vector_erase;
      s += !switched_memory_supply;
    end
    u_board.tamper_erase_in = 1'B0;
    check(k[7:0], 8'H14);
    check(s[7:0], 8'H14);
  endtask
  task automatic t_supply;
    core_chip_enable_n = 4'H5;
    core_rw_n = 1'B0;
    set_warn(1'B1);
    u_board.supply(2'H1);
    step(6);
    check({warn_irq, warn_vector}, 9'H12B);
    check({core_reset, mem_chip_enable_n}, 5'H05);
    set_warn(1'B0);
    step(2);
    check({warn_irq, warn_status}, 2'H1);
    u_board.supply(2'H2);
    step(6);
    check({core_reset, mem_chip_enable_n, mem_rw_n}, 6'H3F);
    u_board.supply(2'H3);
    step(6);
    check({backup_mode, circuits_disable}, 2'H3);
    u_board.supply(2'H0);
    step(6);
    check({core_reset, backup_mode, mem_chip_enable_n}, 6'H05);
  endtask
  initial
  begin
    clk_sys = 1'B0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    #(600 * 50);
    fails++;
    close_out;
  end
  initial
  begin
    warn_enable_wr = 1'B0;
    warn_enable_data = 1'B0;
    core_chip_enable_n = 4'HF;
    core_rw_n = 1'B1;
    do_reset;
    t_pins;
    t_tamper;
    t_supply;
    close_out;
  end
endmodule
bind pfss_top pfss_checker u_chk (.clk_sys, .rst_b, .reset_pin,
  .loader_request_n, .tamper_erase_in, .below_min_operating,
  .below_backup_switch, .warn_enable_wr, .warn_enable_data,
  .core_chip_enable_n, .core_rw_n, .core_reset, .loader_start, .key_erase,
  .switched_memory_supply, .warn_irq, .warn_status, .warn_enable,
  .mem_chip_enable_n, .mem_rw_n);
`default_nettype wire
